// ### test/sync_mem_partner.sv
// Purpose: far-side synchronous memory watching the pins of space 0
// Assumes: pins active low, one space observed
// Notes:   counts clear while clear is high; the bench clears between transfers
`default_nettype none
module sync_mem_partner (
    // clock and clear
    input  wire logic                        clk_sys,
    input  wire logic                        clear,
    // controller pins
    input  wire sync_mem_pkg::sync_pins_type memPins,
    input  wire logic                        writeDataDrive,
    // observations
    output int                               strobeCnt,
    output int                               eventCnt,
    output int                               latency,
    output int                               oeNoCsCnt,
    output int                               csCnt,
    output logic                             lanesLow
);
    timeunit 1ns;
    timeprecision 1ns;
    int   cyc = 0;
    int   firstCs;
    int   firstEvt;
    logic evt;
    // a data beat is either the output-enable slot or the write-data slot
    assign evt = !memPins.oeN || writeDataDrive;
    assign latency = firstEvt - firstCs;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (clear) begin
            {strobeCnt, eventCnt, oeNoCsCnt, csCnt} <= '0;
            lanesLow <= 1'b0;
            firstCs <= -1;
            firstEvt <= -1;
        end else begin
            if (!memPins.chipSelectN[0]) begin
                csCnt <= csCnt + 1;
                if (firstCs < 0) firstCs <= cyc;
                if (memPins.byteLanesN != 8'hff) lanesLow <= 1'b1;
            end
            if (!memPins.strobeN) strobeCnt <= strobeCnt + 1;
            if (evt) eventCnt <= eventCnt + 1;
            if (evt && firstEvt < 0) firstEvt <= cyc;
            if (!memPins.oeN && memPins.chipSelectN[0]) oeNoCsCnt <= oeNoCsCnt + 1;
        end
    end
endmodule // sync_mem_partner
`default_nettype wire

// ### test/sync_mem_space_config_tb_top.sv
// Purpose: self-checking bench for the space configuration block
// Assumes: AXI4-Lite master tasks, space 0 carries the table cases
// Notes:   read latency zero is never programmed, alone or with lane drive
`default_nettype none
module sync_mem_space_config_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 0, rst = 1, clear = 1;
    logic [7:0] awaddr = '0, araddr = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, cmdValid = 0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid, cmdReady, cmdReject, wdd, rcap;
    logic [1:0] bresp, rresp;
    sync_mem_pkg::mem_cmd_type cmdIn = '0;
    sync_mem_pkg::sync_pins_type memPins;
    int strobeCnt, eventCnt, latency, oeNoCsCnt, csCnt, mismatches = 0, checks_done = 0, rejects = 0, caps = 0;
    logic lanesLow;
    logic [1:0] resp;
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) rejects <= rejects + int'(cmdReject);
    always @(posedge clk_sys) caps <= clear ? 0 : caps + int'(rcap);
    sync_mem_space_config sync_mem_space_config_i (.clk_sys, .rst, .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cmdIn,
        .cmdValid, .cmdReady, .cmdReject, .memPins, .writeDataDrive(wdd), .readCapture(rcap));
    sync_mem_partner sync_mem_partner_i (.clk_sys, .clear, .memPins, .writeDataDrive(wdd), .strobeCnt,
        .eventCnt, .latency, .oeNoCsCnt, .csCnt, .lanesLow);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic finish_test();
        if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, 4'hf, 3'b111};
        do begin
            @(posedge clk_sys);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic axiRead(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do begin
            @(posedge clk_sys);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        {d, resp} = {rdata, rresp};
        rready <= 1'b0;
    endtask
    task automatic issue(input logic wr, input logic [1:0] sp);
        @(posedge clk_sys);
        clear <= 1'b0;
        cmdIn <= '{write: wr, space: sp, byteEn: 8'hff};
        cmdValid <= 1'b1;
        do @(posedge clk_sys); while (cmdReady !== 1'b1);
        cmdValid <= 1'b0;
        repeat (3) @(posedge clk_sys);
        while (cmdReady !== 1'b1) @(posedge clk_sys);
        repeat (6) @(posedge clk_sys);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // cfg, write, strobes, beats, latency, lanes driven, deselect flag
    typedef struct {logic [31:0] cfg; logic wr; int stb, evt, lat; logic lanes, desel;} row_type;
    row_type rows[5] = '{'{32'h8000_0007, 0, 1, 1, 1, 0, 1}, '{32'h8000_040c, 0, 8, 8, 3, 1, 1},
        '{32'h8000_0085, 1, 4, 4, 2, 1, 1}, '{32'h8000_0106, 1, 0, 2, 0, 1, 0},
        '{32'h8000_030a, 0, 2, 2, 2, 0, 0}};
    logic [31:0] v;
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        axiRead(8'h00, v);
        check("cfg0 reset", v, 32'h0);
        foreach (rows[i]) begin
            axiWrite(8'h00, rows[i].cfg);
            clear <= 1'b1;
            issue(rows[i].wr, 2'h0);
            check("strobes", strobeCnt, rows[i].stb);
            check("beats", eventCnt, rows[i].evt);
            check("latency", latency, rows[i].lat);
            check("lanes", lanesLow, rows[i].lanes);
            check("captures", caps, rows[i].wr ? 0 : rows[i].evt);
            if (rows[i].cfg[9]) check("oe outside cs", oeNoCsCnt, 0);
            else check("cs cycles", csCnt, rows[i].evt);
            axiRead(8'h10, v);
            check("deselect", v[1], rows[i].desel);
        end
        axiWrite(8'h04, 32'hffff_ffff);
        check("bresp", resp, 32'h0);
        axiRead(8'h04, v);
        check("reserved", v, 32'h8000_07cf);
        issue(1'b1, 2'h1);
        axiWrite(8'h04, 32'h7fff_ffff);
        issue(1'b0, 2'h1);
        check("reject", rejects, 1);
        axiRead(8'h20, v);
        check("unmapped", {v[29:0], resp}, {30'h0, 2'h2});
        finish_test();
    end
    initial begin
        #200000;
        mismatches++;
        finish_test();
    end
endmodule // sync_mem_space_config_tb_top
`default_nettype wire

// ### verilog/sync_delay_line.sv
// Purpose: shift line giving a strobe delayed by one to DEPTH cycles
// Assumes: single clock, asynchronous active-high reset
// Notes:   tap k is the sample taken k cycles earlier
`default_nettype none

module sync_delay_line #(
    parameter int DEPTH = 3
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // data
    input  wire logic             sample,
    output logic      [DEPTH:1]   taps
);

    logic [DEPTH:1] taps_q;
    logic [DEPTH:1] taps_d;

    always_comb begin
        taps_d = {taps_q[DEPTH-1:1], sample};
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            taps_q <= '0;
        end else begin
            taps_q <= taps_d;
        end
    end

    assign taps = taps_q;

endmodule // sync_delay_line

`default_nettype wire

// ### verilog/sync_mem_pkg.sv
// Purpose: constants and types for the synchronous memory space configuration block
// Assumes: four chip-select spaces, AXI4-Lite register access, 100 MHz interface clock
// Notes:   all offsets, field positions and reset values live here
//
// Function
// - top bit picks synchronous or asynchronous mode
// - read byte lanes driven, else held high
// - extend keeps chip select with output enable
// - no extend: chip select ends after command
// - strobe-function set: strobe low only reads
// - read-enable strobe never issues a deselect
// - strobe-function clear: strobe low reads, writes
// - address strobe deselects when nothing pending
// - write latency zero to three cycles
// - read latency one to three cycles
// - bus width eight to sixty-four bits
`default_nettype none

package sync_mem_pkg;

    localparam int          SPACE_COUNT    = 4;
    localparam int          MAX_LATENCY    = 3;
    localparam int          ADDR_W         = 8;
    localparam int          CLK_PERIOD_NS  = 10;

    // register map
    localparam logic [7:0]  ADDR_CFG_BASE  = 8'h00;
    localparam logic [7:0]  ADDR_STATUS    = 8'h10;

    // configuration fields
    localparam int          MODE_BIT       = 31;
    localparam int          RD_LANE_BIT    = 10;
    localparam int          EXTEND_BIT     = 9;
    localparam int          STROBE_FN_BIT  = 8;
    localparam int          WLAT_LSB       = 6;
    localparam int          RLAT_LSB       = 2;
    localparam int          WIDTH_LSB      = 0;
    localparam logic [31:0] CFG_WRITE_MASK = 32'h8000_07cf;
    localparam logic [31:0] CFG_RESET      = 32'h0000_0000;

    // status fields
    localparam int          STAT_BUSY_BIT  = 0;
    localparam int          STAT_DESEL_BIT = 1;

    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef struct packed {
        logic       write;
        logic [1:0] space;
        logic [7:0] byteEn;
    } mem_cmd_type;

    typedef struct packed {
        logic [SPACE_COUNT-1:0] chipSelectN;
        logic                   strobeN;
        logic                   oeN;
        logic [7:0]             byteLanesN;
    } sync_pins_type;

    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'h0,
        SEQ_ISSUE = 2'h1,
        SEQ_DRAIN = 2'h2
    } seq_state_type;

    // beats needed to move one 64-bit word over the configured bus width
    function automatic logic [3:0] beatsFor(input logic [1:0] width);
        unique case (width)
            2'h0: beatsFor = 4'h8;
            2'h1: beatsFor = 4'h4;
            2'h2: beatsFor = 4'h2;
            2'h3: beatsFor = 4'h1;
        endcase
    endfunction

endpackage

`default_nettype wire

// ### verilog/sync_mem_space_config.sv
// Purpose: per-space synchronous memory configuration and pin sequencing
// Assumes: AXI4-Lite slave, one outstanding read and write, 64-bit user word
// Notes:   every pin is registered, so pins trail the internal issue cycle by one
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`default_nettype none

module sync_mem_space_config (
    // clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        rst,
    // axi4-lite write
    input  wire logic [7:0]                  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]                  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    // user command port
    input  wire sync_mem_pkg::mem_cmd_type   cmdIn,
    input  wire logic                        cmdValid,
    output logic                             cmdReady,
    output logic                             cmdReject,
    // memory pins and data timing strobes
    output sync_mem_pkg::sync_pins_type      memPins,
    output logic                             writeDataDrive,
    output logic                             readCapture
);

    ////////////////////////////////////////////////////////////////////////////////
    // register bus

    logic [31:0] cfg_q [sync_mem_pkg::SPACE_COUNT];
    logic [31:0] cfg_d [sync_mem_pkg::SPACE_COUNT];
    logic [7:0]  awAddr_q, awAddr_d;
    logic        awHeld_q, awHeld_d;
    logic [31:0] wData_q, wData_d;
    logic [3:0]  wStrb_q, wStrb_d;
    logic        wHeld_q, wHeld_d;
    logic        bvalid_q, bvalid_d;
    logic [1:0]  bresp_q, bresp_d;
    logic        awready_q, awready_d;
    logic        wready_q, wready_d;
    logic        arready_q, arready_d;
    logic        rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0]  rresp_q, rresp_d;
    logic        busy;
    logic        deselect_q, deselect_d;

    function automatic logic isCfgAddr(input logic [7:0] addr);
        isCfgAddr = (addr[7:4] == sync_mem_pkg::ADDR_CFG_BASE[7:4]) && (addr[1:0] == 2'h0);
    endfunction

    always_comb begin
        logic [31:0] merged;
        merged    = '0;
        cfg_d     = cfg_q;
        awAddr_d  = awAddr_q;
        awHeld_d  = awHeld_q;
        wData_d   = wData_q;
        wStrb_d   = wStrb_q;
        wHeld_d   = wHeld_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        if (s_axi_awvalid && awready_q) begin
            awAddr_d = s_axi_awaddr;
            awHeld_d = 1'b1;
        end
        if (s_axi_wvalid && wready_q) begin
            wData_d = s_axi_wdata;
            wStrb_d = s_axi_wstrb;
            wHeld_d = 1'b1;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (awHeld_q && wHeld_q && !bvalid_q) begin
            awHeld_d = 1'b0;
            wHeld_d  = 1'b0;
            bvalid_d = 1'b1;
            bresp_d  = sync_mem_pkg::RESP_OKAY;
            if (isCfgAddr(awAddr_q)) begin
                merged = cfg_q[awAddr_q[3:2]];
                for (int b = 0; b < 4; b++) begin
                    if (wStrb_q[b]) begin
                        merged[b*8 +: 8] = wData_q[b*8 +: 8];
                    end
                end
                cfg_d[awAddr_q[3:2]] = merged & sync_mem_pkg::CFG_WRITE_MASK;
            end else if (awAddr_q != sync_mem_pkg::ADDR_STATUS) begin
                bresp_d = sync_mem_pkg::RESP_SLVERR;
            end
        end
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d  = sync_mem_pkg::RESP_OKAY;
            rdata_d  = '0;
            if (isCfgAddr(s_axi_araddr)) begin
                rdata_d = cfg_q[s_axi_araddr[3:2]];
            end else if (s_axi_araddr == sync_mem_pkg::ADDR_STATUS) begin
                rdata_d[sync_mem_pkg::STAT_BUSY_BIT]  = busy;
                rdata_d[sync_mem_pkg::STAT_DESEL_BIT] = deselect_q;
            end else begin
                rresp_d = sync_mem_pkg::RESP_SLVERR;
            end
        end
        awready_d = !awHeld_d && !bvalid_d;
        wready_d  = !wHeld_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < sync_mem_pkg::SPACE_COUNT; i++) begin
                cfg_q[i] <= sync_mem_pkg::CFG_RESET;
            end
            awAddr_q  <= 8'h00;
            awHeld_q  <= 1'b0;
            wData_q   <= 32'h0000_0000;
            wStrb_q   <= 4'h0;
            wHeld_q   <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= sync_mem_pkg::RESP_OKAY;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= sync_mem_pkg::RESP_OKAY;
        end else begin
            cfg_q     <= cfg_d;
            awAddr_q  <= awAddr_d;
            awHeld_q  <= awHeld_d;
            wData_q   <= wData_d;
            wStrb_q   <= wStrb_d;
            wHeld_q   <= wHeld_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    ////////////////////////////////////////////////////////////////////////////////
    // command sequencer

    sync_mem_pkg::seq_state_type state_q, state_d;
    sync_mem_pkg::mem_cmd_type   cur_q, cur_d;
    logic [31:0]                 curCfg_q, curCfg_d;
    logic [2:0]                  beat_q, beat_d;
    logic                        ready_q, ready_d;
    logic                        reject_q, reject_d;
    logic                        readIssue, writeIssue;
    logic [3:1]                  rdTaps, wrTaps;
    logic [1:0]                  rdLat, wrLat, busWidth;
    logic                        accept;

    // config is latched per command so a register rewrite cannot bend an access in flight
    assign rdLat      = curCfg_q[sync_mem_pkg::RLAT_LSB +: 2];
    assign wrLat      = curCfg_q[sync_mem_pkg::WLAT_LSB +: 2];
    assign busWidth   = curCfg_q[sync_mem_pkg::WIDTH_LSB +: 2];
    assign readIssue  = (state_q == sync_mem_pkg::SEQ_ISSUE) && !cur_q.write;
    assign writeIssue = (state_q == sync_mem_pkg::SEQ_ISSUE) && cur_q.write;
    assign accept     = cmdValid && ready_q;
    assign busy       = (state_q != sync_mem_pkg::SEQ_IDLE);

    sync_delay_line #(.DEPTH(sync_mem_pkg::MAX_LATENCY)) readDelay (
        .clk_sys (clk_sys),
        .rst     (rst),
        .sample  (readIssue),
        .taps    (rdTaps)
    );

    sync_delay_line #(.DEPTH(sync_mem_pkg::MAX_LATENCY)) writeDelay (
        .clk_sys (clk_sys),
        .rst     (rst),
        .sample  (writeIssue),
        .taps    (wrTaps)
    );

    function automatic logic tapAt(input logic [3:0] line, input logic [1:0] lat);
        tapAt = line[lat];
    endfunction

    // active-high lane enables for one beat; lanes outside the bus width stay off
    function automatic logic [7:0] laneSlice(input logic [7:0] be, input logic [1:0] width, input logic [2:0] beat);
        unique case (width)
            2'h0: laneSlice = {7'h00, be[beat]};
            2'h1: laneSlice = {6'h00, be[{beat[1:0], 1'b0} +: 2]};
            2'h2: laneSlice = {4'h0, be[{beat[0], 2'h0} +: 4]};
            2'h3: laneSlice = be;
        endcase
    endfunction

    always_comb begin
        state_d  = state_q;
        cur_d    = cur_q;
        curCfg_d = curCfg_q;
        beat_d   = beat_q;
        reject_d = 1'b0;
        unique case (state_q)
            sync_mem_pkg::SEQ_IDLE: begin
                if (accept) begin
                    if (cfg_q[cmdIn.space][sync_mem_pkg::MODE_BIT]) begin
                        cur_d    = cmdIn;
                        curCfg_d = cfg_q[cmdIn.space];
                        beat_d   = 3'h0;
                        state_d  = sync_mem_pkg::SEQ_ISSUE;
                    end else begin
                        reject_d = 1'b1;
                    end
                end
            end
            sync_mem_pkg::SEQ_ISSUE: begin
                beat_d = beat_q + 3'h1;
                if ({1'b0, beat_q} == sync_mem_pkg::beatsFor(busWidth) - 4'h1) begin
                    state_d = sync_mem_pkg::SEQ_DRAIN;
                end
            end
            sync_mem_pkg::SEQ_DRAIN: begin
                if (rdTaps == 3'h0 && wrTaps == 3'h0) begin
                    state_d = sync_mem_pkg::SEQ_IDLE;
                end
            end
            default: begin
                state_d = sync_mem_pkg::SEQ_IDLE;
            end
        endcase
        ready_d = (state_d == sync_mem_pkg::SEQ_IDLE);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q  <= sync_mem_pkg::SEQ_IDLE;
            cur_q    <= '0;
            curCfg_q <= sync_mem_pkg::CFG_RESET;
            beat_q   <= 3'h0;
            ready_q  <= 1'b0;
            reject_q <= 1'b0;
        end else begin
            state_q  <= state_d;
            cur_q    <= cur_d;
            curCfg_q <= curCfg_d;
            beat_q   <= beat_d;
            ready_q  <= ready_d;
            reject_q <= reject_d;
        end
    end

    assign cmdReady  = ready_q;
    assign cmdReject = reject_q;

    ////////////////////////////////////////////////////////////////////////////////
    // pin drive

    sync_mem_pkg::sync_pins_type pins_q, pins_d;
    logic                        wrDrive_q, wrDrive_d;
    logic                        rdCap_q, rdCap_d;
    logic                        oeActive, issuing, strobeFn, extend;

    assign issuing  = (state_q == sync_mem_pkg::SEQ_ISSUE);
    assign strobeFn = curCfg_q[sync_mem_pkg::STROBE_FN_BIT];
    assign extend   = curCfg_q[sync_mem_pkg::EXTEND_BIT];
    // latency zero is not a legal read setting; it falls back onto the same-cycle tap
    assign oeActive = tapAt({rdTaps, readIssue}, rdLat);

    always_comb begin
        pins_d             = '1;
        deselect_d         = deselect_q;
        if (issuing) begin
            pins_d.chipSelectN[cur_q.space] = 1'b0;
            // read-enable use keeps the strobe for reads only; address use strobes every command
            pins_d.strobeN = strobeFn ? cur_q.write : 1'b0;
            if (cur_q.write || curCfg_q[sync_mem_pkg::RD_LANE_BIT]) begin
                pins_d.byteLanesN = ~laneSlice(cur_q.byteEn, busWidth, beat_q);
            end
        end else if (state_q == sync_mem_pkg::SEQ_DRAIN) begin
            if (strobeFn) begin
                deselect_d = 1'b0;
            end else begin
                deselect_d = 1'b1;
            end
        end
        if (state_q == sync_mem_pkg::SEQ_IDLE && accept) begin
            deselect_d = 1'b0;
        end
        if (oeActive) begin
            pins_d.oeN = 1'b0;
            if (extend) begin
                pins_d.chipSelectN[cur_q.space] = 1'b0;
            end
        end
        // without extend nothing but an issue cycle pulls chip select low
        wrDrive_d = tapAt({wrTaps, writeIssue}, wrLat);
        rdCap_d   = oeActive;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pins_q     <= '1;
            deselect_q <= 1'b0;
            wrDrive_q  <= 1'b0;
            rdCap_q    <= 1'b0;
        end else begin
            pins_q     <= pins_d;
            deselect_q <= deselect_d;
            wrDrive_q  <= wrDrive_d;
            rdCap_q    <= rdCap_d;
        end
    end

    assign memPins        = pins_q;
    assign writeDataDrive = wrDrive_q;
    assign readCapture    = rdCap_q;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    AST_ASYNC_REFUSE: assert property (@(posedge clk_sys) disable iff (rst)
        (accept && !cfg_q[cmdIn.space][sync_mem_pkg::MODE_BIT]) |=> (cmdReject && state_q == sync_mem_pkg::SEQ_IDLE))
        else $error("command to asynchronous space was not refused");
    AST_READ_LANES_HIGH: assert property (@(posedge clk_sys) disable iff (rst)
        (readIssue && !curCfg_q[sync_mem_pkg::RD_LANE_BIT]) |=> (memPins.byteLanesN == 8'hff))
        else $error("byte lanes driven on read with lane drive off");
    AST_EXTEND_CS: assert property (@(posedge clk_sys) disable iff (rst)
        (!memPins.oeN && extend) |-> !memPins.chipSelectN[cur_q.space])
        else $error("chip select not held with output enable");
    AST_NO_EXTEND_CS: assert property (@(posedge clk_sys) disable iff (rst)
        (!issuing && !extend) |=> (memPins.chipSelectN == '1))
        else $error("chip select stayed low after last command");
    AST_RE_WRITE_HIGH: assert property (@(posedge clk_sys) disable iff (rst)
        (writeIssue && strobeFn) |=> memPins.strobeN)
        else $error("read-enable strobe went low on a write");
    AST_AS_STROBE: assert property (@(posedge clk_sys) disable iff (rst)
        (issuing && !strobeFn) |=> !memPins.strobeN)
        else $error("address strobe missing on command");
    AST_DESELECT: assert property (@(posedge clk_sys) disable iff (rst)
        (state_q == sync_mem_pkg::SEQ_DRAIN && !strobeFn) |=> (memPins.strobeN && deselect_q))
        else $error("no deselect after final command");
    AST_READ_LAT3: assert property (@(posedge clk_sys) disable iff (rst)
        (readIssue && rdLat == 2'h3) |-> ##4 !memPins.oeN)
        else $error("output enable not at read latency three");
    AST_READ_LAT1: assert property (@(posedge clk_sys) disable iff (rst)
        (readIssue && rdLat == 2'h1) |-> ##2 (!memPins.oeN && readCapture))
        else $error("output enable not at read latency one");
    AST_WRITE_LAT0: assert property (@(posedge clk_sys) disable iff (rst)
        (writeIssue && wrLat == 2'h0) |=> writeDataDrive)
        else $error("write data not driven at latency zero");
    AST_WRITE_LAT3: assert property (@(posedge clk_sys) disable iff (rst)
        (writeIssue && wrLat == 2'h3) |-> ##4 writeDataDrive)
        else $error("write data not driven at latency three");
    AST_BEATS_BYTE: assert property (@(posedge clk_sys) disable iff (rst)
        (accept && cfg_q[cmdIn.space][sync_mem_pkg::MODE_BIT] && cfg_q[cmdIn.space][1:0] == 2'h0)
        |=> (state_q == sync_mem_pkg::SEQ_ISSUE) [*8] ##1 (state_q == sync_mem_pkg::SEQ_DRAIN))
        else $error("byte-wide bus did not take eight beats");
    AST_RESERVED_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
        s_axi_rvalid |-> ((s_axi_rdata & ~sync_mem_pkg::CFG_WRITE_MASK) == 32'h0000_0000))
        else $error("reserved bits read nonzero");

endmodule // sync_mem_space_config

`default_nettype wire
